/* File: design/pgmsk_consts.svh */
// Offsets, reset values and field positions of the power-good mask bank.
`ifndef PGMSK_CONSTS_SVH
`define PGMSK_CONSTS_SVH
`define PGMSK_OUT4_RAIL_OFS 8'hA6
`define PGMSK_OUT4_PIN_RAIL_OFS 8'hA7
`define PGMSK_OUT2_RAIL_OFS 8'hA8
`define PGMSK_OUT4_RAIL_RST 8'h00
`define PGMSK_OUT4_PIN_RAIL_RST 8'h00
`define PGMSK_OUT2_RAIL_RST 8'hC0
`define PGMSK_UNMAPPED_RD 8'h00
`define PGMSK_AUX_REG_TWO_BIT 7
`define PGMSK_LOAD_SWITCH_A_BIT 6
`define PGMSK_CONTROL_PIN_FIVE_BIT 7
`define PGMSK_CONTROL_PIN_ONE_BIT 4
`define PGMSK_TERMINATION_REG_BIT 3
`define PGMSK_AUX_REG_THREE_BIT 0
`endif

/* File: design/pgmsk_pkg.sv */
// Types shared by the power-good mask bank.
package pgmsk_pkg;
  typedef logic [7:0] pgmsk_byte_t;
  typedef logic [7:0] pgmsk_addr_t;
endpackage : pgmsk_pkg

/* File: design/pgmsk_regs.sv */
// Power-good tree mask registers and tree evaluation for two outputs.
`timescale 1ns/1ps
`default_nettype none
`include "pgmsk_consts.svh"
// Summary of operation
// - Output four's rail tree takes a source at mask 0, ignores it at 1.
// - Output four's rail mask sits at A6h and resets to zero.
// - A7h bit 7..4 pins 5,4,2,1, bit 3 term, 2..1 switches, 0 aux three.
// - Output four's second mask sits at A7h and resets to zero.
// - Output two's rail mask sits at A8h and resets to C0h.
// - A8h bit 7 aux two, 6 switch A, 5..0 step-down six to one, 1 drops.
module pgmsk_regs (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Register port.
  input wire pgmsk_pkg::pgmsk_addr_t reg_addr_in,
  input wire pgmsk_pkg::pgmsk_byte_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output var pgmsk_pkg::pgmsk_byte_t reg_rdata_out,
  // Power-good sources, asynchronous, high means good.
  input wire logic [7:0] rail_good_in,
  input wire logic [7:0] pin_rail_good_in,
  input wire logic out2_pin_tree_good_in,
  // Power-good indications.
  output logic general_output_four_power_good_out,
  output logic general_output_two_power_good_out
);

  pgmsk_pkg::pgmsk_byte_t mask4a_ff, nxt_mask4a;
  pgmsk_pkg::pgmsk_byte_t mask4b_ff, nxt_mask4b;
  pgmsk_pkg::pgmsk_byte_t mask2a_ff, nxt_mask2a;
  pgmsk_pkg::pgmsk_byte_t rdata_ff, nxt_rdata;
  logic [16:0] sync1_ff, sync2_ff;
  logic [7:0] keep4a, keep4b, keep2a;
  logic good4_ff, nxt_good4, good2_ff, nxt_good2;

  // Mask writes land on the edge of the strobe; reads are registered.
  always_comb
  begin
    nxt_mask4a = mask4a_ff;
    nxt_mask4b = mask4b_ff;
    nxt_mask2a = mask2a_ff;
    nxt_rdata = rdata_ff;
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        `PGMSK_OUT4_RAIL_OFS: nxt_mask4a = reg_wdata_in;
        `PGMSK_OUT4_PIN_RAIL_OFS: nxt_mask4b = reg_wdata_in;
        `PGMSK_OUT2_RAIL_OFS: nxt_mask2a = reg_wdata_in;
        default: ;
      endcase
    end
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `PGMSK_OUT4_RAIL_OFS: nxt_rdata = mask4a_ff;
        `PGMSK_OUT4_PIN_RAIL_OFS: nxt_rdata = mask4b_ff;
        `PGMSK_OUT2_RAIL_OFS: nxt_rdata = mask2a_ff;
        default: nxt_rdata = `PGMSK_UNMAPPED_RD;
      endcase
    end
  end

  // Register stage with documented reset values.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mask4a_ff <= `PGMSK_OUT4_RAIL_RST;
      mask4b_ff <= `PGMSK_OUT4_PIN_RAIL_RST;
      mask2a_ff <= `PGMSK_OUT2_RAIL_RST;
      rdata_ff <= 8'h00;
    end
    else
    begin
      mask4a_ff <= nxt_mask4a;
      mask4b_ff <= nxt_mask4b;
      mask2a_ff <= nxt_mask2a;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_out = rdata_ff;

  // Two-flop synchroniser on every asynchronous source.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1_ff <= 17'h00000;
      sync2_ff <= 17'h00000;
    end
    else
    begin
      sync1_ff <= {out2_pin_tree_good_in, pin_rail_good_in, rail_good_in};
      sync2_ff <= sync1_ff;
    end
  end

  // A source passes when it is good or when its mask bit excludes it.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_term
      assign keep4a[gi] = sync2_ff[gi] | mask4a_ff[gi];
      assign keep4b[gi] = sync2_ff[8 + gi] | mask4b_ff[gi];
      assign keep2a[gi] = sync2_ff[gi] | mask2a_ff[gi];
    end
  endgenerate

  // Each tree is the AND of all its passing terms.
  always_comb
  begin
    nxt_good4 = (&keep4a) & (&keep4b);
    nxt_good2 = (&keep2a) & sync2_ff[16];
  end

  // Indications are registered so the pins never glitch.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      good4_ff <= 1'h0;
      good2_ff <= 1'h0;
    end
    else
    begin
      good4_ff <= nxt_good4;
      good2_ff <= nxt_good2;
    end
  end

  // Outputs come straight from the indication flip-flops.
  assign general_output_four_power_good_out = good4_ff;
  assign general_output_two_power_good_out = good2_ff;

  // Helper flag that marks the first cycle after reset release.
  logic first_ff;
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      first_ff <= 1'h1;
    else
      first_ff <= 1'h0;
  end

  // Checks run on the system clock and rest while reset is low.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // A write strobe at one offset.
  sequence s_write(pgmsk_pkg::pgmsk_addr_t a);
    reg_wr_in && reg_addr_in == a;
  endsequence

  // A lone read strobe at one offset.
  sequence s_read(pgmsk_pkg::pgmsk_addr_t a);
    reg_rd_in && reg_addr_in == a && !reg_wr_in;
  endsequence

  // A write strobe at an offset that holds no mask.
  sequence s_stray_write;
    reg_wr_in && reg_addr_in != `PGMSK_OUT4_RAIL_OFS
      && reg_addr_in != `PGMSK_OUT4_PIN_RAIL_OFS
      && reg_addr_in != `PGMSK_OUT2_RAIL_OFS;
  endsequence

  a_out4_rail_excl: assert property (
    (|(~sync2_ff[7:0] & ~mask4a_ff)) |=> !good4_ff)
    else $error("Unmasked bad rail did not drop output four.");

  a_out4_rail_ignored: assert property (
    (&mask4a_ff && &(sync2_ff[15:8] | mask4b_ff))
      |=> good4_ff)
    else $error("Fully masked rail tree still dropped output four.");

  a_reset_values: assert property (
    first_ff |-> (mask4a_ff == `PGMSK_OUT4_RAIL_RST
      && mask4b_ff == `PGMSK_OUT4_PIN_RAIL_RST
      && mask2a_ff == `PGMSK_OUT2_RAIL_RST))
    else $error("Mask registers left reset with wrong values.");

  a_out4_rail_wr: assert property (
    s_write(8'hA6) |=> mask4a_ff == $past(reg_wdata_in))
    else $error("Write to A6h did not update output four rail mask.");

  a_stray_write: assert property (
    s_stray_write |=> $stable(mask4a_ff) && $stable(mask4b_ff)
      && $stable(mask2a_ff))
    else $error("Write to an unmapped offset changed a mask.");

  a_ctl5_position: assert property (
    (!sync2_ff[15] && !mask4b_ff[`PGMSK_CONTROL_PIN_FIVE_BIT]) |=> !good4_ff)
    else $error("Control pin five term is not at bit 7.");

  a_out4_pin_wr: assert property (
    s_write(8'hA7) |=> mask4b_ff == $past(reg_wdata_in))
    else $error("Write to A7h did not update output four second mask.");

  a_out4_pin_rd: assert property (
    s_write(`PGMSK_OUT4_PIN_RAIL_OFS) ##1 s_read(`PGMSK_OUT4_PIN_RAIL_OFS)
      |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("A7h did not read back what was written.");

  a_out2_rail_wr: assert property (
    s_write(8'hA8) |=> mask2a_ff == $past(reg_wdata_in))
    else $error("Write to A8h did not update output two rail mask.");

  a_out2_aux_excl: assert property (
    (!sync2_ff[`PGMSK_AUX_REG_TWO_BIT] && !mask2a_ff[7]) |=> !good2_ff)
    else $error("Unmasked aux two fault did not drop output two.");

  a_out2_pin_tree: assert property (
    !sync2_ff[16] |=> !good2_ff)
    else $error("Bad pin tree did not drop output two.");

  a_tree_all_good: assert property (
    (&(sync2_ff[7:0] | mask4a_ff)) && (&(sync2_ff[15:8] | mask4b_ff))
      |=> good4_ff)
    else $error("Output four stayed low with every term good.");

  a_out2_all_good: assert property (
    (&(sync2_ff[7:0] | mask2a_ff)) && sync2_ff[16]
      |=> good2_ff)
    else $error("Output two stayed low with every term good.");

endmodule : pgmsk_regs
`default_nettype wire

/* File: verification/pgmsk_host.sv */
// Host model that drives the strobe register port.
`timescale 1ns/1ps
`default_nettype none
module pgmsk_host (
  // Clock and read data.
  input wire logic clk_sys_in,
  input wire logic [7:0] rdata_in,
  // Strobe port.
  output var logic [7:0] addr_out = 8'h00,
  output var logic [7:0] wdata_out = 8'h00,
  output var logic wr_out = 1'h0,
  output var logic rd_out = 1'h0
);
  // Write strobe is one cycle wide, held until the taking edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'h1;
    @(posedge clk_sys_in);
    wr_out <= 1'h0;
  endtask : wr
  // Read data is registered at the taking edge and sampled one edge later.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    rd_out <= 1'h1;
    @(posedge clk_sys_in);
    rd_out <= 1'h0;
    @(posedge clk_sys_in);
    #1 d = rdata_in;
  endtask : rd
  // Write, then read the same offset at the very next edge.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_sys_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'h1;
    @(posedge clk_sys_in);
    wr_out <= 1'h0;
    rd_out <= 1'h1;
    @(posedge clk_sys_in);
    rd_out <= 1'h0;
    @(posedge clk_sys_in);
    #1 q = rdata_in;
  endtask : wr_rd
endmodule : pgmsk_host
`default_nettype wire

/* File: verification/power_good_tree_mask_regs_test.sv */
// Self-checking bench for the power-good mask bank.
`timescale 1ns/1ps
`default_nettype none
module power_good_tree_mask_regs_test;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] rail = 8'hFF;
  logic [7:0] pin = 8'hFF;
  logic o2p = 1'h1;
  logic [7:0] a, wd, rdat, v;
  logic w, r, o4, o2;
  logic [15:0] b;
  logic [7:0] m [3];
  logic [7:0] ofs [3] = '{8'hA6, 8'hA7, 8'hA8};
  int n_fail = 0;
  int checked = 0;
  // Free-running 40 MHz clock.
  initial forever #12.5 clk = ~clk;
  pgmsk_host host (.clk_sys_in(clk), .rdata_in(rdat), .addr_out(a),
    .wdata_out(wd), .wr_out(w), .rd_out(r));
  pgmsk_regs dut (.clk_sys_in(clk), .rst_n_in(rst_n), .reg_addr_in(a),
    .reg_wdata_in(wd), .reg_wr_in(w), .reg_rd_in(r), .reg_rdata_out(rdat),
    .rail_good_in(rail), .pin_rail_good_in(pin),
    .out2_pin_tree_good_in(o2p),
    .general_output_four_power_good_out(o4),
    .general_output_two_power_good_out(o2));
  // Compares one value and counts the outcome.
  task automatic cmp(input string nm, input logic [7:0] e,
    input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  // Writes a mask and keeps the bench copy in step.
  task automatic wm(input int i, input logic [7:0] d);
    host.wr(ofs[i], d);
    m[i] = d;
  endtask : wm
  // Reads a mask back against the bench copy.
  task automatic rchk(input int i);
    host.rd(ofs[i], v);
    cmp("mask", m[i], v);
  endtask : rchk
  // Compares one power-good indication and counts the outcome.
  task automatic cmp_pg(input string nm, input logic e, input logic s);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp_pg
  // Expected level of output four from the bench's mask copies.
  function automatic logic exp_four(input logic [7:0] rl,
    input logic [7:0] pn);
    return &(rl | m[0]) & &(pn | m[1]);
  endfunction : exp_four
  // Expected level of output two from the bench's mask copy.
  function automatic logic exp_two(input logic [7:0] rl, input logic q);
    return &(rl | m[2]) & q;
  endfunction : exp_two
  // Applies source levels and checks both indications once settled.
  task automatic trees(input logic [7:0] rl, input logic [7:0] pn,
    input logic q);
    @(posedge clk);
    rail <= rl;
    pin <= pn;
    o2p <= q;
    repeat (5) @(posedge clk);
    #1 cmp_pg("output_four", exp_four(rl, pn), o4);
    cmp_pg("output_two", exp_two(rl, q), o2);
  endtask : trees
  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // Reset values, unmapped access, bit walk, then random masks.
  initial
  begin
    void'($urandom(32'hFD7C9DC8));
    m = '{8'h00, 8'h00, 8'hC0};
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 3; i++) rchk(i);
    host.wr(8'hA9, 8'h5A);
    host.rd(8'hA9, v);
    cmp("unmapped", 8'h00, v);
    for (int i = 0; i < 3; i++) rchk(i);
    // Back-to-back write and read of output four's second mask.
    host.wr_rd(8'hA7, 8'h3C, v);
    m[1] = 8'h3C;
    cmp("mask", m[1], v);
    wm(1, 8'h00);
    // Every rail of output four masked while every rail is bad.
    wm(0, 8'hFF);
    trees(8'h00, 8'hFF, 1'h1);
    wm(0, 8'h00);
    for (int k = 0; k < 16; k++)
    begin
      b = 16'h0001 << k;
      trees(~b[7:0], ~b[15:8], 1'h1);
      wm(k / 8, b[7:0] | b[15:8]);
      trees(~b[7:0], ~b[15:8], 1'h1);
      wm(k / 8, 8'h00);
    end
    for (int n = 0; n < 40; n++)
    begin
      for (int i = 0; i < 3; i++) wm(i, 8'($urandom));
      trees(8'($urandom | $urandom), 8'($urandom | $urandom),
        1'($urandom));
      rchk(n % 3);
    end
    // A reset in mid-run brings every mask back to its reset value.
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    m = '{8'h00, 8'h00, 8'hC0};
    for (int i = 0; i < 3; i++) rchk(i);
    trees(8'h3F, 8'hFF, 1'h1);
    final_report();
  end
endmodule : power_good_tree_mask_regs_test
`default_nettype wire
